// ==== pkg/scr_defs.svh ====
// Constants of the solenoid current regulator: offsets, reset values, counts.
`ifndef SCR_DEFS_SVH
`define SCR_DEFS_SVH

// ==========================================================
// Register word indices within a channel, and the divider's byte address; channel 1 sits 0x20 above 0.
`define SCR_OFF_SP 3'h0
`define SCR_OFF_DITH 3'h1
`define SCR_OFF_PWM 3'h2
`define SCR_OFF_AZ 3'h3
`define SCR_OFF_FB 3'h4
`define SCR_OFF_DIAG 3'h5
`define SCR_OFF_CLKDIV 8'h40

// ==========================================================
// Reset values and loop constants.
`define SCR_PWM_RST 15'h6064
`define SCR_THR_RST 24'h000400
`define SCR_INT_LIM 24'h3FFFFF
`define SCR_ALIM 24'h000014
`define SCR_GAIN_MAX 3'h6
`define SCR_TOL 12'h008
`define SCR_REGERR_CYC 4'h8
`define SCR_AZ_LAST 4'hF
`define SCR_PER_SAT 16'hFFFF

`endif

// ==== pkg/scr_pkg.sv ====
// Types shared by the solenoid current regulator.
`default_nettype none
package scr_pkg;
  typedef enum logic [1:0] {SCR_OFF, SCR_DRIVE, SCR_RECIRC, SCR_AZERO} scr_state_t;
  typedef struct packed {
    logic alim;
    logic en;
    logic [10:0] value;
  } scr_setpoint_t;
  typedef struct packed {
    logic cfb;
    logic sync;
    logic en;
    logic [5:0] size;
    logic [7:0] steps;
  } scr_dither_t;
  typedef struct packed {
    logic [2:0] gain;
    logic [11:0] period;
  } scr_pwm_t;
  typedef struct packed {
    logic [3:0] m;
    logic [7:0] n;
  } scr_clkdiv_t;
endpackage
`default_nettype wire

// ==== hw/scr_regulator.sv ====
// Two-channel solenoid current regulator with APB register access.
//
// The register addresses and the APB interface to the registers were left to the implementer.
`timescale 1ns/1ps
`default_nettype none
`include "scr_defs.svh"
module scr_regulator
  import scr_pkg::*;
(
  // Clock and reset.
  input wire logic clk_sys,
  input wire logic srst,
  // APB slave.
  input wire logic [7:0] paddr,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  // Channel pins and measured current.
  input wire logic [1:0] en_pin,
  input wire logic [1:0][11:0] cur_sample,
  output logic [1:0] drive_on,
  output logic [1:0] recirc_on
);

  // ========================================================
  // Bus decode.
  wire acc = psel & penable;
  wire wr = acc & pwrite;
  wire setup = psel & ~penable;
  wire [2:0] ridx = paddr[4:2];
  wire div_hit = paddr == `SCR_OFF_CLKDIV;
  wire [1:0] ch_hit;
  wire [1:0][31:0] ch_rdata;
  wire mapped = div_hit | (|ch_hit);
  wire [31:0] rd_mux;

  scr_clkdiv_t div_reg;
  logic az_first_reg;
  logic [23:0] presc_reg;
  logic [31:0] prdata_reg;

  // Zero wait states: data is sampled in setup, so pready rises in access.
  assign pready = acc;
  assign pslverr = acc & ~mapped;
  assign prdata = prdata_reg;
  assign rd_mux = div_hit ? {20'h0, div_reg} :
                  ch_hit[0] ? ch_rdata[0] :
                  ch_hit[1] ? ch_rdata[1] : 32'h0;

  // The first divider write after reset kicks autozero on both channels.
  wire div_wr = wr & div_hit;
  wire az_boot = div_wr & az_first_reg;

  // Dither step length is (n+1) shifted left by m system clocks.
  wire [23:0] step_len = 24'(({16'h0, div_reg.n} + 24'h1) << div_reg.m);
  wire tick = presc_reg >= step_len - 24'h1;

  // Global registers and the read data latch.
  always_ff @(posedge clk_sys) begin
    if (srst) begin
      div_reg <= '0;
      az_first_reg <= 1'b1;
      presc_reg <= 24'h0;
      prdata_reg <= 32'h0;
    end else begin
      if (div_wr) begin
        div_reg <= pwdata[11:0];
        az_first_reg <= 1'b0;
      end
      presc_reg <= tick ? 24'h0 : presc_reg + 24'h1;
      if (setup & ~pwrite) begin
        prdata_reg <= rd_mux;
      end
    end
  end

  // ========================================================
  // Channel logic, one copy per channel.
  for (genvar g = 0; g < 2; g++) begin : ch
    scr_setpoint_t sp_reg;
    scr_dither_t di_pend_reg, di_reg;
    scr_pwm_t pwm_reg;
    scr_state_t st_reg, st_next;
    logic az_go_reg, diag_reg, chg_reg, drun_reg;
    logic [11:0] az_off_reg, fb_cur_reg, fb_per_reg;
    logic [15:0] az_sum_reg, per_reg;
    logic [3:0] az_cnt_reg, chg_cnt_reg;
    logic signed [23:0] integ_reg, thr_reg;
    logic [27:0] sum_reg;
    logic [7:0] mn_reg, mx_reg, fmn_reg, fmx_reg;
    logic [7:0] cyc_reg, fcyc_reg, stp_reg;
    logic [1:0] q_reg;
    logic signed [11:0] dval_reg;

    wire [11:0] smp = cur_sample[g];
    wire [7:0] smp8 = smp[11:4];
    assign ch_hit[g] = paddr[7:6] == 2'h0 && paddr[5] == 1'(g) &&
                       ridx <= `SCR_OFF_DIAG && paddr[1:0] == 2'h0;
    wire hit_wr = wr & ch_hit[g];
    wire sp_wr = hit_wr && ridx == `SCR_OFF_SP;
    wire di_wr = hit_wr && ridx == `SCR_OFF_DITH;
    wire pwm_wr = hit_wr && ridx == `SCR_OFF_PWM;
    wire az_wr = hit_wr && ridx == `SCR_OFF_AZ;
    wire fb_rd = acc & ~pwrite & ch_hit[g] && ridx == `SCR_OFF_FB;
    wire dg_rd = acc & ~pwrite & ch_hit[g] && ridx == `SCR_OFF_DIAG;

    // Channel off on pin low, bit clear or zero setpoint.
    wire active = en_pin[g] & sp_reg.en & (sp_reg.value != 11'h0);
    wire oper = st_reg == SCR_DRIVE || st_reg == SCR_RECIRC;
    // Software start is honoured only with the enable bit clear.
    wire offset_cal_go = az_boot | (az_wr & pwdata[0] & ~sp_reg.en);

    // Offset and dither act on the target, never on the register.
    wire signed [13:0] eff_s = $signed({3'h0, sp_reg.value}) +
      $signed({2'h0, az_off_reg}) + $signed({{2{dval_reg[11]}}, dval_reg});
    wire [11:0] effu = eff_s < 0 ? 12'h0 :
                       eff_s > 14'sh0FFF ? 12'hFFF : eff_s[11:0];

    // Error integrator with normal or auto-limit clamp.
    wire limited = sp_reg.alim & chg_reg;
    wire signed [23:0] lim = limited ? `SCR_ALIM : `SCR_INT_LIM;
    wire signed [23:0] base = st_reg == SCR_OFF ? 24'sh0 : integ_reg;
    wire signed [23:0] isum = base + $signed({12'h0, smp}) - $signed({12'h0, effu});
    wire signed [23:0] iclp = isum > lim ? lim : isum < -lim ? -lim : isum;
    // Under the auto-limit clamp the threshold may be out of reach, so the limit swaps too.
    wire swap = iclp > thr_reg || (limited && iclp == lim);
    wire cyc_end = st_reg == SCR_RECIRC && active && iclp <= 0;
    wire cyc_start = st_next == SCR_DRIVE && st_reg != SCR_DRIVE;

    // Period loop: error scaled by gain and folded into the threshold.
    wire [2:0] gsh = pwm_reg.gain > `SCR_GAIN_MAX ? `SCR_GAIN_MAX : pwm_reg.gain;
    wire signed [12:0] perr = $signed({1'b0, per_reg[15:4]}) -
                              $signed({1'b0, pwm_reg.period});
    wire signed [23:0] pstep = $signed({{11{perr[12]}}, perr}) >>> gsh;
    wire signed [23:0] thr_n = thr_reg - pstep;

    // Setpoint reached when the cycle mean meets the target less a margin.
    wire [11:0] tgt = effu > `SCR_TOL ? effu - `SCR_TOL : 12'h0;
    wire [27:0] sum_n = sum_reg + {16'h0, smp};
    wire [31:0] need = {20'h0, tgt} * {16'h0, per_reg};
    wire reached = {4'h0, sum_n} >= need;

    // Dither boundaries and step events.
    wire steps_ok = di_pend_reg.en && di_pend_reg.steps != 8'h0;
    wire d_go = ~drun_reg & steps_ok & (~di_pend_reg.sync | cyc_start);
    wire q_end = drun_reg & tick && stp_reg == di_reg.steps - 8'h1;
    wire d_end = q_end && q_reg == 2'h3;
    wire d_up = q_reg == 2'h0 || q_reg == 2'h3;
    wire signed [11:0] dsz = $signed({6'h0, di_reg.size});
    wire dith_on = di_reg.en;

    // Controller state machine.
    always_comb begin
      st_next = st_reg;
      unique case (st_reg)
        SCR_OFF: begin
          if (active) begin
            st_next = SCR_DRIVE;
          end
        end
        SCR_DRIVE: begin
          if (!active) begin
            st_next = SCR_OFF;
          end else if (swap) begin
            st_next = SCR_RECIRC;
          end
        end
        SCR_RECIRC: begin
          if (!active) begin
            st_next = SCR_OFF;
          end else if (cyc_end) begin
            st_next = SCR_DRIVE;
          end
        end
        SCR_AZERO: begin
          if (az_cnt_reg == `SCR_AZ_LAST) begin
            st_next = SCR_OFF;
          end
        end
      endcase
      if (offset_cal_go) begin
        st_next = SCR_AZERO;
      end
    end

    // Both switches follow the state, so they can never overlap.
    assign drive_on[g] = st_reg == SCR_DRIVE;
    assign recirc_on[g] = st_reg == SCR_RECIRC;

    // Software registers; the pin pulls the enable bit low.
    always_ff @(posedge clk_sys) begin
      if (srst) begin
        sp_reg <= '0;
        di_pend_reg <= '0;
        pwm_reg <= `SCR_PWM_RST;
      end else begin
        if (sp_wr) begin
          sp_reg <= pwdata[12:0];
        end
        if (!en_pin[g]) begin
          sp_reg.en <= 1'b0;
        end
        if (di_wr) begin
          di_pend_reg <= pwdata[16:0];
        end
        if (pwm_wr) begin
          pwm_reg <= pwdata[14:0];
        end
      end
    end

    // Integrator, period count, threshold and feedback per cycle.
    always_ff @(posedge clk_sys) begin
      if (srst) begin
        st_reg <= SCR_OFF;
        integ_reg <= 24'sh0;
        thr_reg <= `SCR_THR_RST;
        per_reg <= 16'h0;
        sum_reg <= 28'h0;
        fb_cur_reg <= 12'h0;
        fb_per_reg <= 12'h0;
      end else begin
        st_reg <= st_next;
        integ_reg <= oper ? iclp : 24'sh0;
        if (cyc_start || !oper) begin
          per_reg <= 16'h1;
          sum_reg <= {16'h0, smp};
        end else begin
          per_reg <= per_reg == `SCR_PER_SAT ? per_reg : per_reg + 16'h1;
          sum_reg <= sum_n;
        end
        if (cyc_end) begin
          fb_cur_reg <= sum_n[27:16];
          fb_per_reg <= per_reg[15:4];
          thr_reg <= thr_n < 24'sh1 ? 24'sh1 :
                     thr_n > `SCR_INT_LIM ? `SCR_INT_LIM : thr_n;
        end
      end
    end

    // Autozero: average sixteen samples with the stage off.
    always_ff @(posedge clk_sys) begin
      if (srst) begin
        az_go_reg <= 1'b0;
        az_cnt_reg <= 4'h0;
        az_sum_reg <= 16'h0;
        az_off_reg <= 12'h0;
      end else if (offset_cal_go) begin
        az_go_reg <= 1'b1;
        az_cnt_reg <= 4'h0;
        az_sum_reg <= 16'h0;
      end else if (st_reg == SCR_AZERO) begin
        az_cnt_reg <= az_cnt_reg + 4'h1;
        az_sum_reg <= az_sum_reg + {4'h0, smp};
        if (az_cnt_reg == `SCR_AZ_LAST) begin
          az_off_reg <= 12'((az_sum_reg + {4'h0, smp}) >> 4);
          az_go_reg <= 1'b0;
        end
      end
    end

    // Regulator error watch after each setpoint write; set beats read clear.
    always_ff @(posedge clk_sys) begin
      if (srst) begin
        chg_reg <= 1'b0;
        chg_cnt_reg <= 4'h0;
        diag_reg <= 1'b0;
      end else begin
        diag_reg <= diag_reg & ~(dg_rd & prdata_reg[0]);
        if (sp_wr) begin
          chg_reg <= 1'b1;
          chg_cnt_reg <= 4'h0;
        end else if (cyc_end && chg_reg) begin
          if (reached) begin
            chg_reg <= 1'b0;
          end else if (chg_cnt_reg == `SCR_REGERR_CYC - 4'h1) begin
            chg_reg <= 1'b0;
            diag_reg <= 1'b1;
          end else begin
            chg_cnt_reg <= chg_cnt_reg + 4'h1;
          end
        end
      end
    end

    // Dither: new settings load only between periods.
    always_ff @(posedge clk_sys) begin
      if (srst) begin
        di_reg <= '0;
        drun_reg <= 1'b0;
        q_reg <= 2'h0;
        stp_reg <= 8'h0;
        dval_reg <= 12'sh0;
      end else if (d_go) begin
        di_reg <= di_pend_reg;
        drun_reg <= 1'b1;
        q_reg <= 2'h0;
        stp_reg <= 8'h0;
        dval_reg <= 12'sh0;
      end else if (!drun_reg) begin
        di_reg.en <= steps_ok;
      end else if (tick) begin
        dval_reg <= d_up ? dval_reg + dsz : dval_reg - dsz;
        stp_reg <= q_end ? 8'h0 : stp_reg + 8'h1;
        if (q_end) begin
          q_reg <= q_reg + 2'h1;
        end
        if (d_end) begin
          drun_reg <= 1'b0;
        end
      end
    end

    // Extremes and cycle count per dither period, or since the last read.
    always_ff @(posedge clk_sys) begin
      if (srst) begin
        mn_reg <= 8'hFF;
        mx_reg <= 8'h00;
        fmn_reg <= 8'h0;
        fmx_reg <= 8'h0;
        cyc_reg <= 8'h0;
        fcyc_reg <= 8'h0;
      end else if (d_end || (fb_rd && !dith_on) || !oper) begin
        mn_reg <= smp8;
        mx_reg <= smp8;
        cyc_reg <= 8'h0;
        if (d_end) begin
          fmn_reg <= smp8 < mn_reg ? smp8 : mn_reg;
          fmx_reg <= smp8 > mx_reg ? smp8 : mx_reg;
          fcyc_reg <= cyc_reg + {7'h0, cyc_end};
        end
      end else begin
        mn_reg <= smp8 < mn_reg ? smp8 : mn_reg;
        mx_reg <= smp8 > mx_reg ? smp8 : mx_reg;
        if (cyc_end && cyc_reg != 8'hFF) begin
          cyc_reg <= cyc_reg + 8'h1;
        end
      end
    end

    // Feedback word and register read mux.
    wire [7:0] rmn = dith_on ? fmn_reg : mn_reg;
    wire [7:0] rmx = dith_on ? fmx_reg : mx_reg;
    wire [7:0] rcyc = dith_on ? fcyc_reg : 8'h0;
    wire [31:0] fb_word = !oper ? 32'h0 :
      di_pend_reg.cfb ? {8'h0, rcyc, rmx, rmn} :
      {4'h0, fb_per_reg, 4'h0, fb_cur_reg};
    assign ch_rdata[g] =
      ridx == `SCR_OFF_SP ? {19'h0, sp_reg} :
      ridx == `SCR_OFF_DITH ? {15'h0, di_pend_reg} :
      ridx == `SCR_OFF_PWM ? {17'h0, pwm_reg} :
      ridx == `SCR_OFF_AZ ? {12'h0, az_off_reg, 7'h0, az_go_reg} :
      ridx == `SCR_OFF_FB ? fb_word : {31'h0, diag_reg};
  end

endmodule
`default_nettype wire

// ==== dv/scr_load_model.sv ====
// Behavioural solenoid load and current sensor for both regulator channels.
`timescale 1ns/1ps
`default_nettype none
module scr_load_model #(
  parameter logic [11:0] OFS = 12'h011
) (
  // Clock and reset.
  input wire logic clk_sys,
  input wire logic srst,
  // Switch states and sensed current.
  input wire logic [1:0] drive_on,
  input wire logic [1:0] recirc_on,
  output logic [1:0][11:0] cur_sample
);
  logic [1:0][11:0] lvl_reg;
  // =====================================
  // The sensor adds a fixed offset, one more on channel 1, so a calibration is visible.
  assign cur_sample[0] = lvl_reg[0] + OFS;
  assign cur_sample[1] = lvl_reg[1] + OFS + 12'h001;
  // Current climbs while driven, sinks slowly while recirculating and faster with the
  // stage off; the cap keeps the sum from wrapping.
  always_ff @(posedge clk_sys) begin
    for (int c = 0; c < 2; c++) begin
      if (srst) begin
        lvl_reg[c] <= 12'h000;
      end else if (drive_on[c] && lvl_reg[c] < 12'hE00) begin
        lvl_reg[c] <= lvl_reg[c] + 12'h006;
      end else if (!drive_on[c] && lvl_reg[c] > (recirc_on[c] ? 12'h003 : 12'h006)) begin
        lvl_reg[c] <= lvl_reg[c] - (recirc_on[c] ? 12'h003 : 12'h006);
      end else if (!drive_on[c]) begin
        lvl_reg[c] <= 12'h000;
      end
    end
  end
endmodule
`default_nettype wire

// ==== dv/scr_regulator_sva.sv ====
// Port-level assertions for the solenoid current regulator.
`timescale 1ns/1ps
`default_nettype none
module scr_regulator_sva (
  // Clock, reset and bus.
  input wire logic clk_sys,
  input wire logic srst,
  input wire logic [7:0] paddr,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [31:0] pwdata,
  input wire logic [31:0] prdata,
  input wire logic pready,
  input wire logic pslverr,
  // Channel pins and current.
  input wire logic [1:0] en_pin,
  input wire logic [1:0][11:0] cur_sample,
  input wire logic [1:0] drive_on,
  input wire logic [1:0] recirc_on
);
  default clocking @(posedge clk_sys); endclocking
  default disable iff (srst);
  // =====================================
  // Bus decode and a flag so that only the first divider write counts.
  wire logic acc = psel && penable;
  wire logic mapped = paddr == 8'h40 || (paddr[7:6] == 2'h0 && paddr[1:0] == 2'h0
    && paddr[4:2] <= 3'h5);
  logic div_seen_reg;
  always_ff @(posedge clk_sys) begin
    if (srst) begin
      div_seen_reg <= 1'h0;
    end else if (acc && pwrite && paddr == 8'h40) begin
      div_seen_reg <= 1'h1;
    end
  end
  sequence s_first_div;
    acc && pwrite && paddr == 8'h40 && !div_seen_reg;
  endsequence
  sequence s_sp_zero;
    acc && pwrite && paddr == 8'h00 && pwdata[10:0] == 11'h000;
  endsequence
  property p_az_quiet;
    s_first_div |=> (drive_on == 2'h0 && recirc_on == 2'h0) [*8];
  endproperty
  property p_pin_off;
    ((drive_on | recirc_on) & ~en_pin & ~$past(en_pin) & ~$past(en_pin, 2)) == 2'h0;
  endproperty
  property p_sp_zero;
    s_sp_zero |-> ##2 (drive_on[0] == 1'h0 && recirc_on[0] == 1'h0);
  endproperty
  property p_no_both;
    (drive_on & recirc_on) == 2'h0;
  endproperty
  property p_recirc_after_drive;
    $rose(recirc_on[0]) |-> $past(drive_on[0]);
  endproperty
  property p_start_drive;
    $rose(drive_on[0] | recirc_on[0]) |-> drive_on[0];
  endproperty
  property p_bus;
    pready == acc && pslverr == (acc && !mapped);
  endproperty
  property p_hold;
    !(psel && !penable && !pwrite) |=> $stable(prdata);
  endproperty
  property p_fb_idle;
    psel && !penable && !pwrite && paddr == 8'h10 && !drive_on[0] && !recirc_on[0]
      |=> prdata == 32'h0;
  endproperty
  a_az_quiet: assert property (p_az_quiet)
    else $error("switch active during calibration");
  a_pin_off: assert property (p_pin_off)
    else $error("switch active with pin low");
  a_sp_zero: assert property (p_sp_zero)
    else $error("switch active after zero setpoint");
  a_no_both: assert property (p_no_both)
    else $error("both switches on");
  a_recirc_after_drive: assert property (p_recirc_after_drive)
    else $error("recirculation not preceded by drive");
  a_start_drive: assert property (p_start_drive)
    else $error("cycle did not start with drive");
  a_bus: assert property (p_bus)
    else $error("bus answer wrong");
  a_hold: assert property (p_hold)
    else $error("read data changed outside read setup");
  a_fb_idle: assert property (p_fb_idle)
    else $error("feedback not zero on idle channel");
endmodule
`default_nettype wire

// ==== dv/tb_scr_regulator.sv ====
// Self-checking testbench for the solenoid current regulator.
`timescale 1ns/1ps
`default_nettype none
module tb_scr_regulator;
  logic clk_sys = 1'h0;
  logic srst = 1'h1;
  logic [7:0] paddr = 8'h00;
  logic psel = 1'h0;
  logic penable = 1'h0;
  logic pwrite = 1'h0;
  logic [31:0] pwdata = 32'h0;
  logic [31:0] prdata;
  logic pready;
  logic pslverr;
  logic [1:0] en_pin = 2'h3;
  logic [1:0][11:0] cur_sample;
  logic [1:0] drive_on;
  logic [1:0] recirc_on;
  logic [31:0] rd;
  logic err_seen;
  logic recirc_was = 1'h0;
  int err_count = 0;
  int compares = 0;
  int per_cnt = 0;
  int last_per = 0;
  // =====================================
  // Clock, design and load.
  initial begin
    forever #2.5 clk_sys = ~clk_sys;
  end
  scr_regulator i_scr_regulator (.clk_sys, .srst, .paddr, .psel, .penable, .pwrite,
    .pwdata, .prdata, .pready, .pslverr, .en_pin, .cur_sample, .drive_on, .recirc_on);
  scr_load_model i_scr_load_model (.clk_sys, .srst, .drive_on, .recirc_on, .cur_sample);
  // Clocks in the last complete drive cycle of channel 0, counted from drive start.
  always @(posedge clk_sys) begin
    if (drive_on[0] && recirc_was) begin
      last_per = per_cnt;
      per_cnt = 1;
    end else begin
      per_cnt++;
    end
    recirc_was = recirc_on[0];
  end
  task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
    compares++;
    if (seen !== exp) begin
      err_count++;
      $display("wrong value at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask
  task automatic conclude;
    if (err_count == 0 && compares > 0) $display("*** PASS ***");
    else $display("*** FAIL ***");
    $finish;
  endtask
  // One bus transfer; the idle edge first keeps two transfers from colliding.
  task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
    int n;
    @(posedge clk_sys);
    psel <= 1'h1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge clk_sys);
    penable <= 1'h1;
    n = 0;
    do begin
      @(posedge clk_sys);
      n++;
    end while (pready !== 1'h1 && n < 20);
    rd = prdata;
    err_seen = pslverr;
    psel <= 1'h0;
    penable <= 1'h0;
    if (n >= 20) begin
      err_count++;
      conclude();
    end
  endtask
  // Waits for a drive level or for the load to settle, with a bound.
  task automatic wait_for(input logic drv, input logic cur);
    int n;
    n = 0;
    while ((cur ? cur_sample[0] !== 12'h011 : drive_on[0] !== drv) && n < 20000) begin
      @(posedge clk_sys);
      n++;
    end
    if (n >= 20000) begin
      err_count++;
      conclude();
    end
  endtask
  // =====================================
  // Scenarios. Gain stays at its reset index throughout.
  task automatic t_reset;
    apb(1'h0, 8'h08, 32'h0);
    chk(rd, 32'h6064);
    apb(1'h0, 8'h10, 32'h0);
    chk(rd, 32'h0);
    apb(1'h0, 8'h18, 32'h0);
    chk({31'h0, err_seen}, 32'h1);
  endtask
  task automatic t_autozero;
    en_pin <= 2'h1;
    apb(1'h1, 8'h40, 32'h0);
    repeat (20) @(posedge clk_sys);
    apb(1'h0, 8'h0C, 32'h0);
    chk(rd, 32'h1100);
    apb(1'h0, 8'h2C, 32'h0);
    chk(rd, 32'h1200);
    en_pin <= 2'h3;
  endtask
  task automatic t_regulate;
    apb(1'h1, 8'h00, 32'h900);
    apb(1'h0, 8'h00, 32'h0);
    chk(rd, 32'h900);
    repeat (4) begin
      wait_for(1'h0, 1'h0);
      wait_for(1'h1, 1'h0);
    end
    apb(1'h0, 8'h10, 32'h0);
    chk({20'h0, rd[27:16]}, 32'(last_per / 16));
    apb(1'h0, 8'h30, 32'h0);
    chk(rd, 32'h0);
    apb(1'h1, 8'h0C, 32'h1);
    apb(1'h0, 8'h0C, 32'h0);
    chk(rd, 32'h1100);
  endtask
  task automatic t_fb_select;
    apb(1'h1, 8'h04, 32'h10000);
    wait_for(1'h0, 1'h0);
    wait_for(1'h1, 1'h0);
    apb(1'h0, 8'h10, 32'h0);
    chk({24'h0, rd[23:16]}, 32'h0);
    chk(32'(rd[15:8] > rd[7:0]), 32'h1);
    apb(1'h1, 8'h04, 32'h0);
  endtask
  // Slow dither spanning several switching cycles; a stop must let the period finish.
  task automatic t_dither;
    apb(1'h1, 8'h40, 32'hFF);
    apb(1'h1, 8'h04, 32'h14408);
    repeat (17000) @(posedge clk_sys);
    apb(1'h0, 8'h10, 32'h0);
    chk(32'(rd[23:16] != 8'h0), 32'h1);
    chk(32'(rd[15:8] > rd[7:0]), 32'h1);
    apb(1'h1, 8'h04, 32'h10000);
    apb(1'h0, 8'h10, 32'h0);
    chk(32'(rd[23:16] != 8'h0), 32'h1);
    repeat (8500) @(posedge clk_sys);
    apb(1'h0, 8'h10, 32'h0);
    chk({24'h0, rd[23:16]}, 32'h0);
    apb(1'h1, 8'h04, 32'h0);
  endtask
  task automatic t_pin_off;
    en_pin <= 2'h2;
    apb(1'h0, 8'h00, 32'h0);
    chk(rd, 32'h100);
    chk({30'h0, drive_on[0], recirc_on[0]}, 32'h0);
    en_pin <= 2'h3;
  endtask
  // Calibration is only asked for once the coil has let go of its current.
  task automatic t_az_user;
    apb(1'h1, 8'h00, 32'h0);
    wait_for(1'h0, 1'h1);
    apb(1'h1, 8'h0C, 32'h1);
    apb(1'h0, 8'h0C, 32'h0);
    chk({31'h0, rd[0]}, 32'h1);
    repeat (20) @(posedge clk_sys);
    apb(1'h0, 8'h0C, 32'h0);
    chk(rd, 32'h1100);
  endtask
  // A mid-run reset rearms calibration on the next divider write, and only that one.
  task automatic t_rerst;
    srst <= 1'h1;
    repeat (3) @(posedge clk_sys);
    srst <= 1'h0;
    apb(1'h0, 8'h0C, 32'h0);
    chk(rd, 32'h0);
    apb(1'h1, 8'h40, 32'h0);
    apb(1'h0, 8'h0C, 32'h0);
    chk({31'h0, rd[0]}, 32'h1);
    repeat (20) @(posedge clk_sys);
    apb(1'h1, 8'h40, 32'h0);
    apb(1'h0, 8'h0C, 32'h0);
    chk(rd, 32'h1100);
  endtask
  initial begin
    repeat (3) @(posedge clk_sys);
    srst <= 1'h0;
    t_reset();
    t_autozero();
    t_regulate();
    t_fb_select();
    t_dither();
    t_pin_off();
    t_az_user();
    t_rerst();
    conclude();
  end
endmodule
bind scr_regulator scr_regulator_sva i_scr_regulator_sva (.clk_sys, .srst, .paddr, .psel,
  .penable, .pwrite, .pwdata, .prdata, .pready, .pslverr, .en_pin, .cur_sample, .drive_on,
  .recirc_on);
`default_nettype wire
